/* hdl/wtp_watchdog.sv */
// Purpose: watchdog with postscaler, apb registers and event interrupt
// Assumes: mclk is the free-running watchdog oscillator, never gated
// Notes: core instruction strobes are one-cycle pulses on mclk
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module wtp_watchdog
	import wtp_pkg::*;
#(
	parameter int unsigned BASE = BASE_CYCLES
)(
	// clock and reset
	mclk,
	arst_n,
	// apb slave
	paddr,
	psel,
	penable,
	pwrite,
	pwdata,
	prdata,
	pready,
	pslverr,
	// core side
	clearWatchdogInstruction,
	sleepInstruction,
	otherWake,
	watchdogFuseEn,
	// results
	deviceReset,
	wakeCore,
	coreAsleep,
	timeoutStatusFlagN,
	irq
);

	localparam int unsigned BW = $clog2(BASE + 1);

	// clock and reset
	input  wire logic              mclk;
	input  wire logic              arst_n;
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr;
	input  wire logic              psel;
	input  wire logic              penable;
	input  wire logic              pwrite;
	input  wire logic [31:0]       pwdata;
	output logic [31:0]            prdata;
	output logic                   pready;
	output logic                   pslverr;
	// core side
	input  wire logic              clearWatchdogInstruction;
	input  wire logic              sleepInstruction;
	input  wire logic              otherWake;
	input  wire logic              watchdogFuseEn;
	// results
	output logic                   deviceReset;
	output logic                   wakeCore;
	output logic                   coreAsleep;
	output logic                   timeoutStatusFlagN;
	output logic                   irq;

	typedef struct packed {
		logic              fuseMeta;
		logic              fuseSync;
		wtp_mode_t         mode;
		logic              asleep;
		logic [OPT_W-1:0]  option;
		logic              flagN;
		logic [EVT_W-1:0]  evtSts;
		logic [EVT_W-1:0]  evtEn;
		logic              devRst;
		logic              wake;
		logic              irq;
		logic              ready;
		logic              slvErr;
		logic [31:0]       rdata;
	} wtp_main_t;

	wtp_main_t           cur_r;
	wtp_main_t           cur_nxt;

	logic                expire;
	logic                chainClear;
	logic [BW-1:0]       baseCnt;
	logic [PS_CNT_W-1:0] psCnt;
	logic                access;
	logic                wrTake;
	logic                rdPrep;
	logic                mapped;
	logic [EVT_W-1:0]    evtSet;
	logic [EVT_W-1:0]    evtClr;
	logic [31:0]         rdValue;

	// sleep while already asleep does nothing, so it does not clear either
	assign chainClear = clearWatchdogInstruction ||
		(sleepInstruction && cur_r.mode == MODE_RUN);

	wtp_tick_chain #(
		.BASE (BASE),
		.BW   (BW)
	) watchdogCounter (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.run      (cur_r.fuseSync),
		.clear    (chainClear),
		.psAssign (cur_r.option[OPT_ASSIGN]),
		.psSel    (cur_r.option[OPT_PS_LSB +: PS_SEL_W]),
		.expire   (expire),
		.baseCnt  (baseCnt),
		.psCnt    (psCnt)
	);

	// apb: access phase answered one cycle after it opens
	assign access = psel && penable;
	assign rdPrep = access && !cur_r.ready;
	assign wrTake = access && cur_r.ready && pwrite;

	always_comb begin
		case (paddr)
			OFS_OPTION,
			OFS_STATUS,
			OFS_EVTSTS,
			OFS_EVTCLR,
			OFS_EVTEN,
			OFS_COUNT: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		rdValue = '0;
		case (paddr)
			OFS_OPTION: begin
				rdValue[OPT_W-1:0] = cur_r.option;
			end
			OFS_STATUS: begin
				rdValue[STS_TIMEOUT] = cur_r.flagN;
				rdValue[STS_ENABLED] = cur_r.fuseSync;
				rdValue[STS_ASLEEP] = cur_r.asleep;
			end
			OFS_EVTSTS: begin
				rdValue[EVT_W-1:0] = cur_r.evtSts;
			end
			OFS_EVTEN: begin
				rdValue[EVT_W-1:0] = cur_r.evtEn;
			end
			OFS_COUNT: begin
				rdValue[CNT_PS_LSB +: PS_CNT_W] = psCnt;
				rdValue[CNT_BASE_LSB +: BW] = baseCnt;
			end
			default: begin
				rdValue = '0;
			end
		endcase
	end

	// events raised by an expiry, split by the core's state
	always_comb begin
		evtSet = '0;
		evtSet[EVT_RESET] = expire && cur_r.mode == MODE_RUN;
		evtSet[EVT_WAKE] = expire && cur_r.mode == MODE_SLEEP;
		evtClr = '0;
		if (wrTake && paddr == OFS_EVTCLR) begin
			evtClr = pwdata[EVT_W-1:0];
		end
	end

	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.devRst = 1'b0;
		cur_nxt.wake = 1'b0;

		// fuse pin is a strap from outside: two flops before use
		cur_nxt.fuseMeta = watchdogFuseEn;
		cur_nxt.fuseSync = cur_r.fuseMeta;

		// apb handshake
		cur_nxt.ready = rdPrep;
		cur_nxt.slvErr = rdPrep && !mapped;
		if (rdPrep) begin
			cur_nxt.rdata = pwrite ? 32'h0000_0000 : rdValue;
		end
		if (wrTake && paddr == OFS_OPTION) begin
			cur_nxt.option = pwdata[OPT_W-1:0];
		end
		if (wrTake && paddr == OFS_EVTEN) begin
			cur_nxt.evtEn = pwdata[EVT_W-1:0];
		end

		// sticky events: a set in the clearing cycle survives
		cur_nxt.evtSts = (cur_r.evtSts & ~evtClr) | evtSet;

		// clear and sleep restore the flag, an expiry drops it
		if (chainClear) begin
			cur_nxt.flagN = 1'b1;
		end
		if (expire) begin
			cur_nxt.flagN = 1'b0;
		end

		case (cur_r.mode)
			MODE_RUN: begin
				if (expire) begin
					cur_nxt.devRst = 1'b1;
				end else if (sleepInstruction) begin
					cur_nxt.mode = MODE_SLEEP;
				end
			end
			MODE_SLEEP: begin
				if (expire) begin
					cur_nxt.wake = 1'b1;
					cur_nxt.mode = MODE_RUN;
				end else if (otherWake) begin
					cur_nxt.mode = MODE_RUN;
				end
			end
			default: begin
				cur_nxt.mode = MODE_RUN;
			end
		endcase
		cur_nxt.asleep = (cur_nxt.mode == MODE_SLEEP);

		cur_nxt.irq = |(cur_nxt.evtSts & cur_nxt.evtEn);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cur_r.fuseMeta <= 1'b0;
			cur_r.fuseSync <= 1'b0;
			cur_r.mode <= MODE_RUN;
			cur_r.asleep <= 1'b0;
			cur_r.option <= OPTION_RST;
			cur_r.flagN <= TIMEOUT_RST;
			cur_r.evtSts <= EVT_RST;
			cur_r.evtEn <= EVT_RST;
			cur_r.devRst <= 1'b0;
			cur_r.wake <= 1'b0;
			cur_r.irq <= 1'b0;
			cur_r.ready <= 1'b0;
			cur_r.slvErr <= 1'b0;
			cur_r.rdata <= 32'h0000_0000;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign prdata             = cur_r.rdata;
	assign pready             = cur_r.ready;
	assign pslverr            = cur_r.slvErr;
	assign deviceReset        = cur_r.devRst;
	assign wakeCore           = cur_r.wake;
	assign coreAsleep         = cur_r.asleep;
	assign timeoutStatusFlagN = cur_r.flagN;
	assign irq                = cur_r.irq;

	// checks

	reset_on_run_a: assert property (@(posedge mclk) disable iff (!arst_n)
		expire && !coreAsleep |=> deviceReset && !wakeCore)
		else $error("run expiry gave no device reset");

	wake_on_sleep_a: assert property (@(posedge mclk) disable iff (!arst_n)
		expire && coreAsleep |=> wakeCore && !deviceReset && !coreAsleep)
		else $error("sleep expiry did not wake the core");

	fuse_blocks_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!cur_r.fuseSync [*2] |=> !deviceReset && !wakeCore)
		else $error("expiry while fuse disabled");

	flag_on_expire_a: assert property (@(posedge mclk) disable iff (!arst_n)
		expire |=> !timeoutStatusFlagN)
		else $error("time-out flag not cleared on expiry");

	flag_holds_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!timeoutStatusFlagN && !chainClear |=> !timeoutStatusFlagN)
		else $error("time-out flag restored without clear or sleep");

	flag_on_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
		clearWatchdogInstruction && !expire |=> timeoutStatusFlagN ##1 !expire)
		else $error("clear did not restore flag or hold off expiry");

	sleep_counts_a: assert property (@(posedge mclk) disable iff (!arst_n)
		coreAsleep && cur_r.fuseSync && !clearWatchdogInstruction
		&& baseCnt != BW'(BASE - 1) |=> baseCnt == $past(baseCnt) + 1'b1)
		else $error("counter stalled in sleep");

	irq_level_a: assert property (@(posedge mclk) disable iff (!arst_n)
		irq == |(cur_r.evtSts & cur_r.evtEn))
		else $error("interrupt level differs from enabled events");

	apb_answer_a: assert property (@(posedge mclk) disable iff (!arst_n)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle after access");

endmodule

/* shared/wtp_pkg.sv */
// Purpose: constants and types of the watchdog with postscaler
// Assumes: mclk is the watchdog's own free-running oscillator
// Notes: register offsets are byte addresses on APB
//
// What this block does
// - The counter runs from its own free-running oscillator, not the core clock.
// - Counting goes on while the core clock is stopped and the core sleeps.
// - An expiry while the core runs asks for a full device reset.
// - An expiry while the core sleeps wakes it instead of resetting it.
// - A programmed fuse disables the watchdog and software cannot enable it.
// - With no postscaler the time-out is a nominal 18 ms.
// - Software may assign a postscaler of up to 1:128 through the option register.
// - The clear instruction, and the sleep instruction while the core runs, clear the counter and an assigned postscaler.
// - Every expiry clears the active-low time-out flag.
package wtp_pkg;

	// time base
	localparam int unsigned NOMINAL_PERIOD_US = 18000;
	localparam int unsigned CLK_PERIOD_NS     = 50;
	localparam int unsigned BASE_CYCLES       =
		NOMINAL_PERIOD_US * 1000 / CLK_PERIOD_NS;

	// postscaler
	localparam int unsigned PS_SEL_W = 3;
	localparam int unsigned PS_CNT_W = 7;

	// apb map
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0]  OFS_OPTION = 8'h00;
	localparam logic [7:0]  OFS_STATUS = 8'h04;
	localparam logic [7:0]  OFS_EVTSTS = 8'h08;
	localparam logic [7:0]  OFS_EVTCLR = 8'h0C;
	localparam logic [7:0]  OFS_EVTEN  = 8'h10;
	localparam logic [7:0]  OFS_COUNT  = 8'h14;

	// field positions
	localparam int unsigned OPT_PS_LSB   = 0;
	localparam int unsigned OPT_ASSIGN   = 3;
	localparam int unsigned OPT_W        = 4;
	localparam int unsigned STS_TIMEOUT  = 0;
	localparam int unsigned STS_ENABLED  = 1;
	localparam int unsigned STS_ASLEEP   = 2;
	localparam int unsigned EVT_RESET    = 0;
	localparam int unsigned EVT_WAKE     = 1;
	localparam int unsigned EVT_W        = 2;
	localparam int unsigned CNT_PS_LSB   = 0;
	localparam int unsigned CNT_BASE_LSB = 8;

	// values after reset
	localparam logic [3:0] OPTION_RST  = 4'hF;
	localparam logic       TIMEOUT_RST = 1'h1;
	localparam logic [1:0] EVT_RST     = 2'h0;

	typedef enum logic {
		MODE_RUN,
		MODE_SLEEP
	} wtp_mode_t;

endpackage

/* hdl/wtp_tick_chain.sv */
// Purpose: base counter and postscaler of the watchdog
// Assumes: BASE of at least two cycles
// Notes: expire is a one-cycle pulse from a flip-flop
`timescale 1ns/10ps
module wtp_tick_chain
	import wtp_pkg::*;
#(
	parameter int unsigned BASE = BASE_CYCLES,
	parameter int unsigned BW   = $clog2(BASE + 1)
)(
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                arst_n,
	// control
	input  wire logic                run,
	input  wire logic                clear,
	input  wire logic                psAssign,
	input  wire logic [PS_SEL_W-1:0] psSel,
	// results
	output logic                     expire,
	output logic [BW-1:0]            baseCnt,
	output logic [PS_CNT_W-1:0]      psCnt
);

	typedef struct packed {
		logic [BW-1:0]       base;
		logic [PS_CNT_W-1:0] ps;
		logic                exp;
	} wtp_chain_t;

	wtp_chain_t          cur_r;
	wtp_chain_t          cur_nxt;
	logic [PS_CNT_W-1:0] lastPs;
	logic                baseTop;
	logic                psTop;

	assign lastPs  = PS_CNT_W'((8'h01 << psSel) - 8'h01);
	assign baseTop = (cur_r.base == BW'(BASE - 1));
	// >= so a ratio cut short mid-count still ends when the current base period ends
	assign psTop   = !psAssign || (cur_r.ps >= lastPs);

	always_comb begin
		cur_nxt = cur_r;
		cur_nxt.exp = 1'b0;
		if (clear || !run) begin
			cur_nxt.base = '0;
			cur_nxt.ps = '0;
		end else if (baseTop) begin
			cur_nxt.base = '0;
			if (psTop) begin
				cur_nxt.ps = '0;
				cur_nxt.exp = 1'b1;
			end else begin
				cur_nxt.ps = cur_r.ps + 1'b1;
			end
		end else begin
			cur_nxt.base = cur_r.base + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign expire  = cur_r.exp;
	assign baseCnt = cur_r.base;
	assign psCnt   = cur_r.ps;

	base_advance_a: assert property (@(posedge mclk) disable iff (!arst_n)
		run && !clear && !baseTop |=> baseCnt == $past(baseCnt) + 1'b1)
		else $error("base count did not advance");
	period_end_a: assert property (@(posedge mclk) disable iff (!arst_n)
		run && !clear && baseTop && psTop |=> expire)
		else $error("no expiry at end of period");
	clear_count_a: assert property (@(posedge mclk) disable iff (!arst_n)
		clear |=> baseCnt == '0 && psCnt == '0 ##1 !expire)
		else $error("clear did not zero the chain");
	ratio_hit_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(expire) && $past(psAssign) |-> $past(psCnt) >= $past(lastPs))
		else $error("expiry before postscaler ratio");

endmodule

/* tb/wtp_watchdog_test.sv */
// Purpose: self-checking bench of the watchdog with postscaler
// Assumes: BASE shortened to 8 cycles so every ratio fits a short run
// Notes: outputs sampled on the falling edge, away from register updates
`timescale 1ns/10ps
module wtp_watchdog_test
	import wtp_pkg::*;
;
	localparam int unsigned BASE = 8;
	logic              mclk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, junk;
	logic              clearWatchdogInstruction, sleepInstruction, otherWake;
	logic              watchdogFuseEn, deviceReset, wakeCore, coreAsleep;
	logic              timeoutStatusFlagN, irq, irqAtAns;
	int                errCount, checkCount, cyc, rstCnt, wakeCnt, tMark, t0, n;
	logic [1:0]        expEvt, expEn;

	wtp_watchdog #(.BASE(BASE)) uut (.mclk(mclk), .arst_n(arst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clearWatchdogInstruction(clearWatchdogInstruction),
		.sleepInstruction(sleepInstruction), .otherWake(otherWake),
		.watchdogFuseEn(watchdogFuseEn), .deviceReset(deviceReset),
		.wakeCore(wakeCore), .coreAsleep(coreAsleep),
		.timeoutStatusFlagN(timeoutStatusFlagN), .irq(irq));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// pulse outputs last one cycle, so they are counted on every falling edge
	always @(negedge mclk) begin
		cyc++;
		if (deviceReset === 1'b1) rstCnt++;
		if (wakeCore === 1'b1) wakeCnt++;
	end

	task automatic results();
		$display("checks %0d errors %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp, input string what);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chkPin(input logic got, input logic exp, input string what);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		irqAtAns = irq;
		@(posedge mclk);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			chkPin(1'b0, 1'b1, "apb timeout");
			results();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chkReg(r, exp, "read data");
		chkPin(e, expErr, "read error");
		chkPin(irqAtAns, |(expEvt & expEn), "irq level");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic expErr);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chkPin(e, expErr, "write error");
	endtask

	// 0 clear, 1 sleep, 2 other wake source
	task automatic pulse(input int k);
		@(posedge mclk);
		clearWatchdogInstruction <= (k == 0);
		sleepInstruction         <= (k == 1);
		otherWake                <= (k == 2);
		@(posedge mclk);
		clearWatchdogInstruction <= 1'b0;
		sleepInstruction         <= 1'b0;
		otherWake                <= 1'b0;
		tMark = cyc;
		@(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic waitExp(input int nom, input int start, input logic slp);
		int k;
		k = 0;
		while (deviceReset !== 1'b1 && wakeCore !== 1'b1 && k < nom + 40) begin
			@(negedge mclk);
			k++;
		end
		chkPin(cyc - start >= nom - 1 && cyc - start <= nom + 5, 1'b1, "expiry time");
		chkPin(slp ? wakeCore : deviceReset, 1'b1, "expiry pin");
		chkPin(slp ? deviceReset : wakeCore, 1'b0, "wrong expiry pin");
		chkPin(timeoutStatusFlagN, 1'b0, "flag after expiry");
		chkPin(coreAsleep, 1'b0, "asleep after expiry");
		expEvt = expEvt | (slp ? 2'h2 : 2'h1);
		if (k >= nom + 40) results();
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{clearWatchdogInstruction, sleepInstruction, otherWake} = '0;
		{errCount, checkCount, cyc, rstCnt, wakeCnt} = '0;
		{expEvt, expEn} = '0;
		watchdogFuseEn = 1'b1;
		arst_n = 1'b0;
		void'($urandom(62));
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;

		rd(OFS_OPTION, 32'h0000000F, 1'b0);
		wr(OFS_STATUS, $urandom, 1'b0);
		rd(OFS_STATUS, 32'h00000003, 1'b0);
		rd(OFS_EVTSTS, 32'h0, 1'b0);
		rd(OFS_EVTEN, 32'h0, 1'b0);
		rd(OFS_EVTCLR, 32'h0, 1'b0);
		wr(8'h40, $urandom, 1'b1);
		rd(8'h40, 32'h0, 1'b1);
		$display("test registers done");

		for (int i = 7; i >= 0; i--) begin
			junk = $urandom & 32'hFFFFFFF0;
			wr(OFS_OPTION, junk | 32'h8 | i, 1'b0);
			pulse(0);
			chkPin(timeoutStatusFlagN, 1'b1, "flag after clear");
			waitExp(BASE << i, tMark, 1'b0);
		end
		wr(OFS_OPTION, $urandom_range(0, 7), 1'b0);
		pulse(0);
		waitExp(BASE, tMark, 1'b0);
		wr(OFS_OPTION, 32'hF, 1'b0);
		pulse(0);
		$display("test ratios done");

		wr(OFS_OPTION, 32'h9, 1'b0);
		n = rstCnt;
		repeat (12) begin
			repeat ($urandom_range(2, 9)) @(posedge mclk);
			pulse(0);
		end
		chkReg(rstCnt, n, "reset despite clears");
		$display("test clears done");

		wr(OFS_EVTEN, 32'h3, 1'b0);
		expEn = 2'h3;
		wr(OFS_OPTION, 32'hB, 1'b0);
		pulse(1);
		t0 = tMark;
		chkPin(coreAsleep, 1'b1, "asleep");
		chkPin(timeoutStatusFlagN, 1'b1, "flag after sleep");
		rd(OFS_STATUS, 32'h00000007, 1'b0);
		repeat (20) @(posedge mclk);
		pulse(1);
		waitExp(BASE * 8, t0, 1'b1);
		wr(OFS_OPTION, 32'hF, 1'b0);
		pulse(0);
		wr(OFS_EVTSTS, 32'h0, 1'b0);
		rd(OFS_EVTSTS, 32'h3, 1'b0);
		wr(OFS_EVTCLR, 32'h1, 1'b0);
		expEvt = 2'h2;
		rd(OFS_EVTSTS, 32'h2, 1'b0);
		wr(OFS_EVTEN, 32'h1, 1'b0);
		expEn = 2'h1;
		rd(OFS_EVTEN, 32'h1, 1'b0);
		wr(OFS_EVTCLR, 32'h2, 1'b0);
		expEvt = 2'h0;
		rd(OFS_EVTSTS, 32'h0, 1'b0);
		$display("test sleep and irq done");

		n = wakeCnt;
		pulse(1);
		pulse(2);
		chkPin(coreAsleep, 1'b0, "other wake");
		chkReg(wakeCnt, n, "wake pulse on other wake");
		pulse(0);
		$display("test other wake done");

		@(posedge mclk);
		watchdogFuseEn <= 1'b0;
		repeat (4) @(posedge mclk);
		rd(OFS_STATUS, 32'h00000001, 1'b0);
		wr(OFS_OPTION, 32'hFFFFFFF0, 1'b0);
		rd(OFS_OPTION, 32'h0, 1'b0);
		pulse(0);
		n = rstCnt;
		repeat (300) @(posedge mclk);
		chkReg(rstCnt, n, "expiry with fuse off");
		wr(OFS_COUNT, $urandom, 1'b0);
		rd(OFS_COUNT, 32'h0, 1'b0);
		$display("test fuse done");
		results();
	end
endmodule
